// file: src/step_arith_unit.sv
// serial step add, subtract, multiply and divide datapath with apb access
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
//
// Contract
// - all working registers 40 bits, sign leftmost
// - accumulator feeds adder; operand gated in
// - add result displaced left, diagonal right
// - accumulator right shifts take the extension bit as the new sign
// - subtract gates inverted operand to adder
// - inverted operand always adds carry one
// - multiply fetches multiplicand, clears accumulator
// - rounded and unrounded multiply variants supported
// - add multiplicand when quotient lsb set
// - unrounded spill enters quotient; rounded zeros
// - multiply sum loaded direct, shift right
// - counter loads 23, loop ends at 63
// - full counter tests sign, corrects, rounds
// - correction subtracts, shifts quotient, clears sign
// - rounded multiply sets accumulator lsb one
// - multiply extension bit takes operand sign on add, else accumulator sign
// - divide fetches divisor, clears quotient, copies sign
// - signs agree subtract, set bit; else add
// - quotient shifts left; remainder transferred left
// - forty division steps form pseudo quotient
// - sign compare uses remainder extension bit
// - division rounds by setting quotient lsb
module step_arith_unit
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [step_arith_pkg::ADDR_W-1:0] paddr,
    input wire logic [step_arith_pkg::DATA_W-1:0] pwdata,
    output logic [step_arith_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // order status
    output logic busy,
    output logic order_done
);
    import step_arith_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    seq_state_t state_ff;
    logic step_phase_ff;
    logic [CTR_W-1:0] ops_ctr_ff;
    logic [OP_W-1:0] order_reg_ff;
    logic done_flag_ff;
    logic [0:WORD_W-1] mem_word_ff;
    logic [0:WORD_W-1] operand_reg_ff;
    logic [0:WORD_W-1] acc_main_ff;
    logic [0:WORD_W-1] acc_shift_buffer_ff;
    logic sum_extension_bit_ff;
    logic [0:WORD_W-1] quo_main_ff;
    logic remainder_extension_bit_ff;
    logic [DATA_W-1:0] prdata_ff;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic acc_sign_bit;
    logic quo_lsb;
    logic operand_sign_bit;
    logic rounded_multiply;
    logic is_div;
    logic is_idle;
    logic wr_acc;
    logic rd_setup;
    logic mapped;
    logic accept;
    logic transfer;
    logic agree;
    logic [CTR_W-1:0] ctr_inc;

    assign acc_sign_bit = acc_main_ff[0];
    assign quo_lsb = quo_main_ff[WORD_W-1];
    assign operand_sign_bit = operand_reg_ff[0];
    assign rounded_multiply = (order_reg_ff == OP_MUL_RO);
    assign is_div = (order_reg_ff == OP_DIV);
    assign is_idle = (state_ff == ST_IDLE);
    assign ctr_inc = ops_ctr_ff + 6'h01;
    // remainder extension against divisor sign
    assign agree = (remainder_extension_bit_ff == operand_sign_bit);

    // apb strobes; the slave never inserts wait states
    assign wr_acc = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = psel & penable;
    assign prdata = prdata_ff;

    // address map check
    always_comb
    begin
        case (paddr)
            OFF_ORDER, OFF_STATUS, OFF_OPND_LO, OFF_OPND_HI,
            OFF_ACC_LO, OFF_ACC_HI, OFF_QUO_LO, OFF_QUO_HI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~mapped;

    // an order is taken only while idle and only with a known code
    assign accept = wr_acc & (paddr == OFF_ORDER) & is_idle & (pwdata[OP_W-1:0] <= OP_DIV);

    // second phase of an arithmetic step moves the buffer into the main register
    always_comb
    begin
        case (state_ff)
            ST_ADDSUB, ST_MUL_ITER, ST_MUL_CORR, ST_DIV_STEP: transfer = step_phase_ff;
            default: transfer = 1'b0;
        endcase
    end

    assign busy = ~is_idle;
    assign order_done = (state_ff == ST_DONE);

    // ----------------------------------------------------------------
    // adder
    // ----------------------------------------------------------------
    logic gate_true;
    logic gate_comp;
    logic [0:WORD_W-1] adder_b;
    logic [0:WORD_W-1] sum;

    // choose true or complement gating of the operand
    always_comb
    begin
        gate_true = 1'b0;
        gate_comp = 1'b0;
        case (state_ff)
            ST_ADDSUB:
            begin
                gate_true = (order_reg_ff == OP_ADD);
                gate_comp = (order_reg_ff == OP_SUB);
            end
            ST_MUL_ITER: gate_true = quo_lsb;
            ST_MUL_CORR: gate_comp = quo_lsb;
            ST_DIV_STEP:
            begin
                gate_comp = agree;
                gate_true = ~agree;
            end
            default:
            begin
                gate_true = 1'b0;
                gate_comp = 1'b0;
            end
        endcase
    end

    // operand reaches the adder only through a gate
    assign adder_b = gate_true ? operand_reg_ff : (gate_comp ? ~operand_reg_ff : WORD_RESET);
    // accumulator is wired to the adder permanently; complement gate injects carry
    assign sum = acc_main_ff + adder_b + {39'h0, gate_comp};

    // ----------------------------------------------------------------
    // buffer load, first phase of a step
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_shift_buffer_ff <= WORD_RESET;
            sum_extension_bit_ff <= 1'b0;
        end
        else if (!step_phase_ff)
        begin
            case (state_ff)
                ST_ADDSUB, ST_MUL_CORR:
                begin
                    // sum enters displaced one place left
                    acc_shift_buffer_ff <= {sum[1:WORD_W-1], 1'b0};
                    sum_extension_bit_ff <= sum[0];
                end
                ST_MUL_ITER:
                begin
                    // sum enters direct; extension bit is not fed by the adder
                    acc_shift_buffer_ff <= sum;
                    sum_extension_bit_ff <= gate_true ? operand_sign_bit : acc_sign_bit;
                end
                ST_DIV_STEP:
                begin
                    acc_shift_buffer_ff <= sum;
                    sum_extension_bit_ff <= sum[0];
                end
                default:
                begin
                    acc_shift_buffer_ff <= acc_shift_buffer_ff;
                    sum_extension_bit_ff <= sum_extension_bit_ff;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_IDLE;
            step_phase_ff <= 1'b0;
            ops_ctr_ff <= CTR_RESET;
            order_reg_ff <= OP_ADD;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    step_phase_ff <= 1'b0;
                    if (accept)
                    begin
                        order_reg_ff <= pwdata[OP_W-1:0];
                        case (pwdata[OP_W-1:0])
                            OP_MUL, OP_MUL_RO:
                            begin
                                ops_ctr_ff <= MUL_CTR_LOAD;
                                state_ff <= ST_MUL_FETCH;
                            end
                            OP_DIV:
                            begin
                                ops_ctr_ff <= CTR_RESET;
                                state_ff <= ST_DIV_STEP;
                            end
                            default: state_ff <= ST_ADDSUB;
                        endcase
                    end
                end
                ST_MUL_FETCH:
                begin
                    // the fetch cycle counts as the first multiply cycle
                    ops_ctr_ff <= ctr_inc;
                    state_ff <= ST_MUL_ITER;
                end
                ST_ADDSUB:
                begin
                    step_phase_ff <= ~step_phase_ff;
                    if (step_phase_ff)
                    begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_MUL_ITER:
                begin
                    step_phase_ff <= ~step_phase_ff;
                    if (step_phase_ff)
                    begin
                        ops_ctr_ff <= ctr_inc;
                        if (ctr_inc == CTR_FULL)
                        begin
                            state_ff <= ST_MUL_CORR;
                        end
                    end
                end
                ST_MUL_CORR:
                begin
                    step_phase_ff <= ~step_phase_ff;
                    if (step_phase_ff)
                    begin
                        state_ff <= rounded_multiply ? ST_ROUND : ST_DONE;
                    end
                end
                ST_DIV_STEP:
                begin
                    step_phase_ff <= ~step_phase_ff;
                    if (step_phase_ff)
                    begin
                        ops_ctr_ff <= ctr_inc;
                        if (ctr_inc == DIV_STEPS)
                        begin
                            state_ff <= ST_ROUND;
                        end
                    end
                end
                ST_ROUND: state_ff <= ST_DONE;
                ST_DONE: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // done flag for software polling; a new order clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_flag_ff <= 1'b0;
        end
        else if (state_ff == ST_DONE)
        begin
            done_flag_ff <= 1'b1;
        end
        else if (accept)
        begin
            done_flag_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // memory word staging and operand register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_word_ff <= WORD_RESET;
        end
        else if (wr_acc && paddr == OFF_OPND_LO)
        begin
            mem_word_ff[HI_W:WORD_W-1] <= pwdata;
        end
        else if (wr_acc && paddr == OFF_OPND_HI)
        begin
            mem_word_ff[0:HI_W-1] <= pwdata[HI_W-1:0];
        end
    end

    // operand is fetched at acceptance and held until the order ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            operand_reg_ff <= WORD_RESET;
        end
        else if (accept)
        begin
            operand_reg_ff <= mem_word_ff;
        end
    end

    // ----------------------------------------------------------------
    // main accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_main_ff <= WORD_RESET;
        end
        else if (is_idle)
        begin
            if (accept && (pwdata[OP_W-1:0] == OP_MUL || pwdata[OP_W-1:0] == OP_MUL_RO))
            begin
                acc_main_ff <= WORD_RESET;
            end
            else if (wr_acc && paddr == OFF_ACC_LO)
            begin
                acc_main_ff[HI_W:WORD_W-1] <= pwdata;
            end
            else if (wr_acc && paddr == OFF_ACC_HI)
            begin
                acc_main_ff[0:HI_W-1] <= pwdata[HI_W-1:0];
            end
        end
        else if (transfer)
        begin
            if (state_ff == ST_DIV_STEP)
            begin
                // diagonal left: remainder arrives doubled
                acc_main_ff <= {acc_shift_buffer_ff[1:WORD_W-1], 1'b0};
            end
            else
            begin
                // diagonal right with the extension bit as the new sign
                acc_main_ff <= {sum_extension_bit_ff, acc_shift_buffer_ff[0:WORD_W-2]};
            end
        end
        else if (state_ff == ST_ROUND && !is_div)
        begin
            acc_main_ff[WORD_W-1] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // quotient register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quo_main_ff <= WORD_RESET;
        end
        else if (is_idle)
        begin
            if (accept && pwdata[OP_W-1:0] == OP_DIV)
            begin
                quo_main_ff <= WORD_RESET;
            end
            else if (wr_acc && paddr == OFF_QUO_LO)
            begin
                quo_main_ff[HI_W:WORD_W-1] <= pwdata;
            end
            else if (wr_acc && paddr == OFF_QUO_HI)
            begin
                quo_main_ff[0:HI_W-1] <= pwdata[HI_W-1:0];
            end
        end
        else if (transfer)
        begin
            case (state_ff)
                ST_MUL_ITER:
                begin
                    // spilled product bit enters at the left unless rounding
                    quo_main_ff <= {rounded_multiply ? 1'b0 : acc_shift_buffer_ff[WORD_W-1],
                                    quo_main_ff[0:WORD_W-2]};
                end
                ST_MUL_CORR: quo_main_ff <= {1'b0, quo_main_ff[0:WORD_W-2]};
                ST_DIV_STEP: quo_main_ff <= {quo_main_ff[1:WORD_W-2], agree, 1'b0};
                default: quo_main_ff <= quo_main_ff;
            endcase
        end
        else if (state_ff == ST_ROUND)
        begin
            if (is_div)
            begin
                quo_main_ff[WORD_W-1] <= 1'b1;
            end
            else
            begin
                quo_main_ff <= WORD_RESET;
            end
        end
    end

    // ----------------------------------------------------------------
    // remainder extension bit
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            remainder_extension_bit_ff <= 1'b0;
        end
        else if (accept && pwdata[OP_W-1:0] == OP_DIV)
        begin
            remainder_extension_bit_ff <= acc_sign_bit;
        end
        else if (transfer && state_ff == ST_DIV_STEP)
        begin
            remainder_extension_bit_ff <= sum_extension_bit_ff;
        end
    end

    // ----------------------------------------------------------------
    // apb read data, captured in the setup cycle
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0000_0000;
        end
        else if (rd_setup)
        begin
            case (paddr)
                OFF_ORDER: prdata_ff <= {29'h0, order_reg_ff};
                OFF_STATUS:
                begin
                    prdata_ff <= 32'h0000_0000;
                    prdata_ff[STAT_BUSY_BIT] <= busy;
                    prdata_ff[STAT_DONE_BIT] <= done_flag_ff;
                    prdata_ff[STAT_CTR_LSB +: CTR_W] <= ops_ctr_ff;
                end
                OFF_OPND_LO: prdata_ff <= operand_reg_ff[HI_W:WORD_W-1];
                OFF_OPND_HI: prdata_ff <= {24'h00_0000, operand_reg_ff[0:HI_W-1]};
                OFF_ACC_LO: prdata_ff <= acc_main_ff[HI_W:WORD_W-1];
                OFF_ACC_HI: prdata_ff <= {24'h00_0000, acc_main_ff[0:HI_W-1]};
                OFF_QUO_LO: prdata_ff <= quo_main_ff[HI_W:WORD_W-1];
                OFF_QUO_HI: prdata_ff <= {24'h00_0000, quo_main_ff[0:HI_W-1]};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// file: src/step_arith_pkg.sv
// constants, encodings and register map of the serial step arithmetic unit
package step_arith_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int WORD_W = 40;
    localparam int CTR_W = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int HI_W = 8;
    localparam int OP_W = 3;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_ORDER = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_OPND_LO = 8'h08;
    localparam logic [7:0] OFF_OPND_HI = 8'h0C;
    localparam logic [7:0] OFF_ACC_LO = 8'h10;
    localparam logic [7:0] OFF_ACC_HI = 8'h14;
    localparam logic [7:0] OFF_QUO_LO = 8'h18;
    localparam logic [7:0] OFF_QUO_HI = 8'h1C;
    // ----------------------------------------------------------------
    // status fields
    // ----------------------------------------------------------------
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_CTR_LSB = 8;
    // ----------------------------------------------------------------
    // order codes
    // ----------------------------------------------------------------
    localparam logic [2:0] OP_ADD = 3'h0;
    localparam logic [2:0] OP_SUB = 3'h1;
    localparam logic [2:0] OP_MUL = 3'h2;
    localparam logic [2:0] OP_MUL_RO = 3'h3;
    localparam logic [2:0] OP_DIV = 3'h4;
    // ----------------------------------------------------------------
    // counter values and reset values
    // ----------------------------------------------------------------
    localparam logic [5:0] CTR_RESET = 6'h00;
    localparam logic [5:0] MUL_CTR_LOAD = 6'h17;
    localparam logic [5:0] CTR_FULL = 6'h3F;
    localparam logic [5:0] DIV_STEPS = 6'h28;
    localparam logic [39:0] WORD_RESET = 40'h00_0000_0000;
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDSUB = 3'b001,
        ST_MUL_FETCH = 3'b010,
        ST_MUL_ITER = 3'b011,
        ST_MUL_CORR = 3'b100,
        ST_ROUND = 3'b101,
        ST_DIV_STEP = 3'b110,
        ST_DONE = 3'b111
    } seq_state_t;
endpackage

// file: tb/step_arith_assertions.sv
// port-level checker of the serial step arithmetic unit
`timescale 1ns/1ps
module step_arith_assertions
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [step_arith_pkg::ADDR_W-1:0] paddr,
    input wire logic [step_arith_pkg::DATA_W-1:0] pwdata,
    input wire logic [step_arith_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // order status
    input wire logic busy,
    input wire logic order_done
);
    import step_arith_pkg::*;
    logic take;
    // order write seen while the unit is idle
    assign take = psel && penable && pwrite && paddr == OFF_ORDER && !busy;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_done_pulse: assert property (order_done |=> !order_done)
        else $error("done held too long");
    chk_done_idle: assert property (order_done |=> !busy)
        else $error("busy after done");
    chk_busy_rise: assert property (take && pwdata[2:0] <= OP_DIV |=> busy)
        else $error("order not started");
    chk_bad_code: assert property (take && pwdata[2:0] > OP_DIV |=> !busy)
        else $error("unknown code started");
    chk_addsub_time: assert property (take && pwdata[2:1] == 2'h0 |=> (busy && !order_done)[*2] ##1 order_done)
        else $error("add time wrong");
    chk_mul_time: assert property (take && pwdata[2:0] == OP_MUL |-> ##82 order_done)
        else $error("multiply time wrong");
    chk_mulro_time: assert property (take && pwdata[2:0] == OP_MUL_RO |-> ##83 order_done)
        else $error("rounded multiply time wrong");
    chk_div_time: assert property (take && pwdata[2:0] == OP_DIV |-> ##82 order_done)
        else $error("divide time wrong");
endmodule
bind step_arith_unit step_arith_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .busy, .order_done);

// file: tb/order_seq_model.sv
// apb model of the sequencer that issues arithmetic orders
`timescale 1ns/1ps
module order_seq_model
(
    // clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [step_arith_pkg::ADDR_W-1:0] paddr,
    output logic [step_arith_pkg::DATA_W-1:0] pwdata,
    input wire logic [step_arith_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // wait ran out
    output logic hung
);
    import step_arith_pkg::*;
    // idle bus at time zero
    initial
    begin
        {psel, penable, pwrite, hung} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 16);
        q = prdata;
        e = pslverr;
        hung <= (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~a; // released lines do not keep the old value
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule

// file: tb/tb_step_arith_unit.sv
// self-checking bench of the serial step arithmetic unit
`timescale 1ns/1ps
module tb_step_arith_unit;
    import step_arith_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel, penable, pwrite, pready, pslverr, busy, order_done, hung, err, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [39:0] v, a, d, q, s;
    logic signed [79:0] p;
    int errors = 0;
    int n_tests = 0;
    // free-running 20 MHz clock
    always #25 pclk = ~pclk;
    step_arith_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .busy, .order_done);
    order_seq_model seq (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hung);
    // a stuck bus ends the run
    always @(posedge hung)
    begin
        errors++;
        conclude();
    end
    // compare one value and count it
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // counts and verdict
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // 40-bit values travel as high word then low word
    task automatic put(input logic [7:0] ad, input logic [39:0] val);
        seq.xfer(1'h1, ad + 8'h04, {24'h0, val[39:32]}, rd, err);
        seq.xfer(1'h1, ad, val[31:0], rd, err);
    endtask
    task automatic get(input logic [7:0] ad, output logic [39:0] val);
        seq.xfer(1'h0, ad + 8'h04, 32'h0, rd, err);
        val[39:32] = rd[7:0];
        seq.xfer(1'h0, ad, 32'h0, rd, err);
        val[31:0] = rd;
    endtask
    // bounded wait for the unit to go idle
    task automatic idle;
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300)
        begin
            errors++;
            conclude();
        end
    endtask
    task automatic run(input logic [2:0] op);
        seq.xfer(1'h1, OFF_ORDER, {29'h0, op}, rd, err);
        idle();
    endtask
    // main sequence
    initial
    begin
        p = $signed(40'hC3_1234_5678) * $signed(40'h5A_0F0F_00F1);
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        get(OFF_QUO_LO, v);
        check(v, WORD_RESET);
        put(OFF_ACC_LO, 40'h12_3456_789A);
        put(OFF_OPND_LO, 40'h0F_EDCB_A987);
        run(OP_ADD);
        get(OFF_ACC_LO, v);
        check(v, 40'h22_2222_2221);
        put(OFF_ACC_LO, 40'h00_0000_0000);
        put(OFF_OPND_LO, 40'h00_0000_0001);
        run(OP_SUB);
        get(OFF_ACC_LO, v);
        check(v, 40'hFF_FFFF_FFFF);
        $display("test add and subtract ended");
        for (int k = 0; k < 2; k++)
        begin
            put(OFF_QUO_LO, 40'hC3_1234_5678);
            put(OFF_OPND_LO, 40'h5A_0F0F_00F1);
            put(OFF_ACC_LO, 40'h11_1111_1111);
            run(k ? OP_MUL_RO : OP_MUL);
            get(OFF_ACC_LO, v);
            check(v, k ? {p[78:40], 1'h1} : p[78:39]);
            get(OFF_QUO_LO, v);
            check(v, k ? 40'h0 : {1'h0, p[38:0]});
        end
        seq.xfer(1'h0, OFF_STATUS, 32'h0, rd, err);
        check({34'h0, rd[13:8]}, {34'h0, CTR_FULL});
        check({38'h0, rd[1:0]}, 40'h2);
        $display("test multiply ended");
        a = 40'h48_0000_0000;
        d = 40'h98_0000_0000;
        q = 40'h0;
        put(OFF_ACC_LO, a);
        put(OFF_QUO_LO, 40'hFF_FFFF_FFFF);
        put(OFF_OPND_LO, d);
        run(OP_DIV);
        // non-restoring steps worked out here
        e = a[39];
        repeat (40)
        begin
            s = (e == d[39]) ? a - d : a + d;
            q = {q[38:1], e == d[39], 1'h0};
            e = s[39];
            a = {s[38:0], 1'h0};
        end
        q[0] = 1'h1;
        get(OFF_QUO_LO, v);
        check(v, q);
        get(OFF_ACC_LO, v);
        check(v, a);
        $display("test divide ended");
        seq.xfer(1'h1, OFF_ORDER, 32'h5, rd, err);
        check({39'h0, busy}, 40'h0);
        seq.xfer(1'h1, OFF_ORDER, {29'h0, OP_DIV}, rd, err);
        seq.xfer(1'h1, OFF_ORDER, {29'h0, OP_ADD}, rd, err);
        seq.xfer(1'h0, OFF_ORDER, 32'h0, rd, err);
        check({37'h0, rd[2:0]}, {37'h0, OP_DIV});
        seq.xfer(1'h0, 8'h20, 32'h0, rd, err);
        check({7'h0, err, rd}, {8'h1, 32'h0});
        idle();
        $display("test refusals ended");
        conclude();
    end
endmodule
